// ==== uma_pkg.sv ====
package uma_pkg;

  // register indices as printed; byte address is four times the index
  localparam logic [31:0] SUMMARY_INDEX = 32'h5000180C;
  localparam logic [31:0] MASK_INDEX = 32'h5000180E;
  localparam logic [31:0] LATCH_INDEX = 32'h50001810;

  localparam int REG_W = 16;
  localparam logic [REG_W-1:0] SUMMARY_RESET = 16'h0000;
  localparam logic [REG_W-1:0] MASK_RESET = 16'h0000;
  localparam logic [REG_W-1:0] LATCH_RESET = 16'h0000;
  localparam logic [REG_W-1:0] MASK_WRITABLE = 16'h0FFF;
  localparam logic [REG_W-1:0] SUMMARY_READABLE = 16'h0F7F;

  // summary and mask bit positions
  localparam int FIFO_WARNING_BIT = 0;
  localparam int ALTERNATE_GROUP_BIT = 1;
  localparam int TRANSMIT_GROUP_BIT = 2;
  localparam int FRAME_UPDATE_BIT = 3;
  localparam int REFUSAL_GROUP_BIT = 4;
  localparam int FRAME_LOCK_CHANGE_BIT = 5;
  localparam int RECEIVE_GROUP_BIT = 6;
  localparam int MASTER_IRQ_ENABLE_BIT = 7;
  localparam int CTRL_EP_TRANSMIT_BIT = 8;
  localparam int CTRL_EP_RECEIVE_BIT = 9;
  localparam int CTRL_EP_REFUSAL_BIT = 10;
  localparam int CHARGER_CHANGE_BIT = 11;

  localparam int CHARGER_BITS = 3;
  localparam int CTRL_EP = 0;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // software reads of neighbouring registers that clear summary bits
  typedef struct packed {
    logic ctrl_ep_refusal_register;
    logic ctrl_ep_receive_status;
    logic ctrl_ep_transmit_status;
    logic refusal_event_register;
    logic alternate_event_register;
    logic fifo_warning_register;
    logic charger_status;
  } uma_reads_t;

  // single-bit sources from endpoint 0 and frame timer
  typedef struct packed {
    logic ctrl_ep_out_refused;
    logic ctrl_ep_in_refused;
    logic ctrl_ep_receive_done;
    logic ctrl_ep_transmit_done;
    logic frame_timer_lock_indicator;
    logic frame_update;
  } uma_ctrl_src_t;

endpackage

// ==== uma_event_aggregator.sv ====
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/100ps
module uma_event_aggregator #(
  parameter int NUM_EP = 4,
  parameter int ALT_W = 8,
  parameter int NAK_W = 8,
  parameter int WARN_W = 8,
  parameter int ADDR_W = 12
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire uma_pkg::uma_ctrl_src_t ctrl_src,
  input wire uma_pkg::uma_reads_t reads,
  input wire logic [NUM_EP-1:0] receive_done,
  input wire logic [NUM_EP-1:0] receive_overrun_flag,
  input wire logic [NUM_EP-1:0] receive_event_mask,
  input wire logic [NUM_EP-1:0] transmit_done,
  input wire logic [NUM_EP-1:0] transmit_underrun_flag,
  input wire logic [NUM_EP-1:0] transmit_event_mask,
  input wire logic [NAK_W-1:0] refusal_event_register,
  input wire logic [NAK_W-1:0] refusal_event_mask,
  input wire logic [ALT_W-1:0] alternate_event_register,
  input wire logic [ALT_W-1:0] alternate_event_mask,
  input wire logic [WARN_W-1:0] fifo_warning_register,
  input wire logic [WARN_W-1:0] fifo_warning_mask,
  input wire logic [uma_pkg::CHARGER_BITS-1:0] charger_status,
  output logic irq
);

  // parameters the logic cannot serve stop elaboration
  if (NUM_EP < 2 || NUM_EP <= uma_pkg::CTRL_EP)
  begin : g_bad_num_ep
    $error("uma_event_aggregator: NUM_EP must be at least 2");
  end
  if (ALT_W < 1 || NAK_W < 1 || WARN_W < 1)
  begin : g_bad_event_width
    $error("uma_event_aggregator: event widths must be at least 1");
  end
  if (ADDR_W < 7 || ADDR_W > 32)
  begin : g_bad_addr_width
    $error("uma_event_aggregator: ADDR_W must lie in 7 to 32");
  end

  localparam logic [ADDR_W-1:0] SUMMARY_ADDR = ADDR_W'({uma_pkg::SUMMARY_INDEX, 2'b00});
  localparam logic [ADDR_W-1:0] MASK_ADDR = ADDR_W'({uma_pkg::MASK_INDEX, 2'b00});
  localparam logic [ADDR_W-1:0] LATCH_ADDR = ADDR_W'({uma_pkg::LATCH_INDEX, 2'b00});

  typedef struct packed {
    logic awready;
    logic wready;
    logic have_aw;
    logic have_w;
    logic [ADDR_W-1:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [uma_pkg::REG_W-1:0] summary;
    logic [uma_pkg::REG_W-1:0] mask;
    logic [uma_pkg::REG_W-1:0] latch;
    logic prev_refused;
    logic prev_receive;
    logic prev_transmit;
    logic prev_lock;
    logic [NAK_W-1:0] prev_nak;
    logic [ALT_W-1:0] prev_alt;
    logic [WARN_W-1:0] prev_warn;
    logic [uma_pkg::CHARGER_BITS-1:0] prev_charger;
    logic irq;
  } uma_state_t;

  uma_state_t state;
  uma_state_t next_state;

  // byte-lane merge of a write into a 16-bit register
  function automatic logic [uma_pkg::REG_W-1:0] merge_lanes(
    input logic [uma_pkg::REG_W-1:0] old_value,
    input logic [31:0] data,
    input logic [3:0] strb
  );
    logic [uma_pkg::REG_W-1:0] result;
    result = old_value;
    for (int i = 0; i < uma_pkg::REG_W / 8; i++)
    begin
      if (strb[i])
      begin
        result[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return result;
  endfunction

  // sticky flag: set wins over clear
  function automatic logic sticky(
    input logic old_value,
    input logic set_now,
    input logic clear_now
  );
    return set_now | (old_value & ~clear_now);
  endfunction

  function automatic logic known_addr(input logic [ADDR_W-1:0] addr);
    return addr == SUMMARY_ADDR || addr == MASK_ADDR || addr == LATCH_ADDR;
  endfunction

  logic [NUM_EP-1:0] overrun_usable;
  logic [NUM_EP-1:0] underrun_usable;
  logic refused_now;
  logic [NAK_W-1:0] nak_masked;
  logic [ALT_W-1:0] alt_masked;
  logic [WARN_W-1:0] warn_masked;
  logic nak_now;
  logic alt_now;
  logic warn_now;
  logic rx_group_set;
  logic rx_group_idle;
  logic tx_group_set;
  logic tx_group_idle;
  logic summary_read;
  logic latch_read;
  logic [uma_pkg::REG_W-1:0] summary_view;

  always_comb
  begin
    overrun_usable = receive_overrun_flag;
    underrun_usable = transmit_underrun_flag;
    overrun_usable[uma_pkg::CTRL_EP] = 1'b0;
    underrun_usable[uma_pkg::CTRL_EP] = 1'b0;
    refused_now = ctrl_src.ctrl_ep_out_refused | ctrl_src.ctrl_ep_in_refused;
    // per-bit rise, so a new bit counts even while another stays set
    nak_masked = refusal_event_register & refusal_event_mask;
    alt_masked = alternate_event_register & alternate_event_mask;
    warn_masked = fifo_warning_register & fifo_warning_mask;
    nak_now = |(nak_masked & ~state.prev_nak);
    alt_now = |(alt_masked & ~state.prev_alt);
    warn_now = |(warn_masked & ~state.prev_warn);
    rx_group_set = |((receive_done | overrun_usable) & receive_event_mask);
    rx_group_idle = ~|(receive_done | overrun_usable);
    tx_group_set = |((transmit_done | underrun_usable) & transmit_event_mask);
    tx_group_idle = ~|(transmit_done | underrun_usable);
    summary_view = state.summary & uma_pkg::SUMMARY_READABLE;
  end

  always_comb
  begin
    next_state = state;
    summary_read = 1'b0;
    latch_read = 1'b0;

    // write address and data, taken in either order
    if (s_axi_awvalid && state.awready)
    begin
      next_state.waddr = s_axi_awaddr;
      next_state.have_aw = 1'b1;
    end
    if (s_axi_wvalid && state.wready)
    begin
      next_state.wdata = s_axi_wdata;
      next_state.wstrb = s_axi_wstrb;
      next_state.have_w = 1'b1;
    end
    if (state.bvalid && s_axi_bready)
    begin
      next_state.bvalid = 1'b0;
    end
    if (state.have_aw && state.have_w && !state.bvalid)
    begin
      next_state.have_aw = 1'b0;
      next_state.have_w = 1'b0;
      next_state.bvalid = 1'b1;
      next_state.bresp = known_addr(state.waddr) ? uma_pkg::RESP_OKAY : uma_pkg::RESP_DECERR;
      if (state.waddr == MASK_ADDR)
      begin
        next_state.mask = merge_lanes(state.mask, state.wdata, state.wstrb)
          & uma_pkg::MASK_WRITABLE;
      end
    end
    next_state.awready = !next_state.have_aw && !next_state.bvalid;
    next_state.wready = !next_state.have_w && !next_state.bvalid;

    // read: data captured now, read clears applied to the same edge
    if (state.rvalid && s_axi_rready)
    begin
      next_state.rvalid = 1'b0;
    end
    if (s_axi_arvalid && state.arready)
    begin
      next_state.rvalid = 1'b1;
      next_state.rresp = known_addr(s_axi_araddr) ? uma_pkg::RESP_OKAY : uma_pkg::RESP_DECERR;
      next_state.rdata = 32'h00000000;
      if (s_axi_araddr == SUMMARY_ADDR)
      begin
        next_state.rdata = {16'h0000, summary_view};
        summary_read = 1'b1;
      end
      else if (s_axi_araddr == MASK_ADDR)
      begin
        next_state.rdata = {16'h0000, state.mask};
      end
      else if (s_axi_araddr == LATCH_ADDR)
      begin
        next_state.rdata = {16'h0000, state.latch};
        latch_read = 1'b1;
      end
    end
    next_state.arready = !next_state.rvalid;

    // summary flags
    next_state.summary[uma_pkg::CHARGER_CHANGE_BIT] = sticky(
      state.summary[uma_pkg::CHARGER_CHANGE_BIT],
      charger_status != state.prev_charger,
      reads.charger_status);
    next_state.summary[uma_pkg::CTRL_EP_REFUSAL_BIT] = sticky(
      state.summary[uma_pkg::CTRL_EP_REFUSAL_BIT],
      refused_now & ~state.prev_refused,
      reads.ctrl_ep_refusal_register);
    next_state.summary[uma_pkg::CTRL_EP_RECEIVE_BIT] = sticky(
      state.summary[uma_pkg::CTRL_EP_RECEIVE_BIT],
      ctrl_src.ctrl_ep_receive_done & ~state.prev_receive,
      reads.ctrl_ep_receive_status);
    next_state.summary[uma_pkg::CTRL_EP_TRANSMIT_BIT] = sticky(
      state.summary[uma_pkg::CTRL_EP_TRANSMIT_BIT],
      ctrl_src.ctrl_ep_transmit_done & ~state.prev_transmit,
      reads.ctrl_ep_transmit_status);
    next_state.summary[uma_pkg::MASTER_IRQ_ENABLE_BIT] = 1'b0;
    next_state.summary[uma_pkg::RECEIVE_GROUP_BIT] = sticky(
      state.summary[uma_pkg::RECEIVE_GROUP_BIT], rx_group_set, rx_group_idle);
    next_state.summary[uma_pkg::FRAME_LOCK_CHANGE_BIT] = sticky(
      state.summary[uma_pkg::FRAME_LOCK_CHANGE_BIT],
      ctrl_src.frame_timer_lock_indicator != state.prev_lock,
      summary_read);
    next_state.summary[uma_pkg::REFUSAL_GROUP_BIT] = sticky(
      state.summary[uma_pkg::REFUSAL_GROUP_BIT],
      nak_now,
      reads.refusal_event_register);
    next_state.summary[uma_pkg::FRAME_UPDATE_BIT] = sticky(
      state.summary[uma_pkg::FRAME_UPDATE_BIT],
      ctrl_src.frame_update,
      summary_read);
    next_state.summary[uma_pkg::TRANSMIT_GROUP_BIT] = sticky(
      state.summary[uma_pkg::TRANSMIT_GROUP_BIT], tx_group_set, tx_group_idle);
    next_state.summary[uma_pkg::ALTERNATE_GROUP_BIT] = sticky(
      state.summary[uma_pkg::ALTERNATE_GROUP_BIT],
      alt_now,
      reads.alternate_event_register);
    next_state.summary[uma_pkg::FIFO_WARNING_BIT] = sticky(
      state.summary[uma_pkg::FIFO_WARNING_BIT],
      warn_now,
      reads.fifo_warning_register);
    next_state.summary[uma_pkg::REG_W-1:uma_pkg::CHARGER_CHANGE_BIT+1] = '0;

    // sticky capture of each summary bit rising, cleared by its read
    for (int i = 0; i < uma_pkg::REG_W; i++)
    begin
      next_state.latch[i] = sticky(state.latch[i],
        next_state.summary[i] & ~state.summary[i], latch_read);
    end

    next_state.prev_refused = refused_now;
    next_state.prev_receive = ctrl_src.ctrl_ep_receive_done;
    next_state.prev_transmit = ctrl_src.ctrl_ep_transmit_done;
    next_state.prev_lock = ctrl_src.frame_timer_lock_indicator;
    next_state.prev_nak = nak_masked;
    next_state.prev_alt = alt_masked;
    next_state.prev_warn = warn_masked;
    next_state.prev_charger = charger_status;

    // level interrupt from the next summary and mask
    next_state.irq = next_state.mask[uma_pkg::MASTER_IRQ_ENABLE_BIT]
      & |(next_state.summary & next_state.mask);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state <= '0;
      state.awready <= 1'b1;
      state.wready <= 1'b1;
      state.arready <= 1'b1;
      state.summary <= uma_pkg::SUMMARY_RESET;
      state.mask <= uma_pkg::MASK_RESET;
      state.latch <= uma_pkg::LATCH_RESET;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign s_axi_awready = state.awready;
  assign s_axi_wready = state.wready;
  assign s_axi_bvalid = state.bvalid;
  assign s_axi_bresp = state.bresp;
  assign s_axi_arready = state.arready;
  assign s_axi_rvalid = state.rvalid;
  assign s_axi_rdata = state.rdata;
  assign s_axi_rresp = state.rresp;
  assign irq = state.irq;

endmodule // uma_event_aggregator

// ==== uma_event_aggregator_assertions.sv ====
`timescale 1ns/100ps
module uma_event_aggregator_assertions #(
  parameter int NUM_EP = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire uma_pkg::uma_reads_t reads,
  input wire logic [NUM_EP-1:0] receive_done,
  input wire logic [NUM_EP-1:0] transmit_done,
  input wire logic irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_read_latency: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
  a_rvalid_cause: assert property (
    $rose(s_axi_rvalid) |-> $past(s_axi_arvalid && s_axi_arready)) else $error("stray rvalid");
  a_rdata_stands: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  a_upper_zero: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000) else $error("upper half not zero");
  a_read_refused: assert property (
    s_axi_rvalid |-> !s_axi_arready) else $error("read taken while answering");
  a_write_refused: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken while answering");
  a_bvalid_stands: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("write answer dropped");
  a_write_answer: assert property (
    !s_axi_awready && !s_axi_wready && !s_axi_bvalid |=> s_axi_bvalid)
    else $error("write answer late");
  a_irq_fall_cause: assert property (
    $fell(irq) |-> $past(|reads) || $past(s_axi_arvalid && s_axi_arready) || $rose(s_axi_bvalid)
      || $past(receive_done == '0 || transmit_done == '0)) else $error("irq fell without cause");
  c_irq_rise: cover property ($rose(irq));
  c_read_clear: cover property (|reads ##1 $fell(irq));
  c_write_done: cover property (s_axi_bvalid && s_axi_bready);
endmodule // uma_event_aggregator_assertions

bind uma_event_aggregator uma_event_aggregator_assertions #(.NUM_EP(NUM_EP)) u_chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .reads(reads), .receive_done(receive_done),
  .transmit_done(transmit_done), .irq(irq));

// ==== uma_evt_model.sv ====
`timescale 1ns/100ps
module uma_evt_model (
  input wire logic aclk,
  output uma_pkg::uma_ctrl_src_t ctrl_src,
  output uma_pkg::uma_reads_t reads,
  output logic [3:0] rxd, ovr, rxm, txd, und, txm,
  output logic [7:0] nak, nakm, alt, altm, warn, warnm,
  output logic [2:0] chg
);
  initial
  begin
    {ctrl_src, reads, rxd, ovr, txd, und, nak, alt, warn, chg} = '0;
    {rxm, txm, nakm, altm, warnm} = '1;
  end
  // raise one event source; toggled sources make a change each call
  task automatic fire(input int b);
    @(posedge aclk);
    case (b)
      0: warn[0] <= 1'h1;
      1: alt[3] <= 1'h1;
      2: txd[1] <= 1'h1;
      3: ctrl_src.frame_update <= 1'h1;
      4: nak[0] <= 1'h1;
      5: ctrl_src.frame_timer_lock_indicator <= !ctrl_src.frame_timer_lock_indicator;
      6: rxd[1] <= 1'h1;
      8: ctrl_src.ctrl_ep_transmit_done <= 1'h1;
      9: ctrl_src.ctrl_ep_receive_done <= 1'h1;
      10: ctrl_src.ctrl_ep_in_refused <= 1'h1;
      11: chg[0] <= !chg[0];
      default: ;
    endcase
    @(posedge aclk);
    ctrl_src.frame_update <= 1'h0;
  endtask
  // software read of the source register also empties it, except charger status, which is only read; receive and transmit group sources
  // are dropped without a read, and the frame sources are left to the summary read
  task automatic clear(input int b);
    @(posedge aclk);
    case (b)
      0: {warn[0], reads.fifo_warning_register} <= 2'h1;
      1: {alt[3], reads.alternate_event_register} <= 2'h1;
      2: txd[1] <= 1'h0;
      4: {nak[0], reads.refusal_event_register} <= 2'h1;
      6: rxd[1] <= 1'h0;
      8: {ctrl_src.ctrl_ep_transmit_done, reads.ctrl_ep_transmit_status} <= 2'h1;
      9: {ctrl_src.ctrl_ep_receive_done, reads.ctrl_ep_receive_status} <= 2'h1;
      10: {ctrl_src.ctrl_ep_in_refused, reads.ctrl_ep_refusal_register} <= 2'h1;
      11: reads.charger_status <= 1'h1;
      default: ;
    endcase
    @(posedge aclk);
    reads <= '0;
  endtask
  task automatic fault(input logic [3:0] v);
    @(posedge aclk);
    ovr <= v;
    und <= v;
    @(posedge aclk);
  endtask
endmodule // uma_evt_model

// ==== uma_event_aggregator_tb.sv ====
`timescale 1ns/100ps
module uma_event_aggregator_tb;
  localparam logic [11:0] SUM_A = 12'(uma_pkg::SUMMARY_INDEX << 2);
  localparam logic [11:0] MASK_A = 12'(uma_pkg::MASK_INDEX << 2);
  localparam logic [11:0] LATCH_A = 12'(uma_pkg::LATCH_INDEX << 2);
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [11:0] awaddr = '0, araddr = '0;
  logic awvalid = 1'h0, wvalid = 1'h0, arvalid = 1'h0, bready = 1'h1, rready = 1'h1;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = 4'hF;
  logic [2:0] prot = 3'h0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  uma_pkg::uma_ctrl_src_t ctrl_src;
  uma_pkg::uma_reads_t reads;
  logic [3:0] rxd, ovr, rxm, txd, und, txm;
  logic [7:0] nak, nakm, alt, altm, warn, warnm;
  logic [2:0] chg;
  int fail_count = 0;
  int comparisons = 0;
  int cycles = 0;
  int bits[11] = '{0, 1, 2, 3, 4, 5, 6, 8, 9, 10, 11};

  uma_event_aggregator uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awprot(prot), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(prot),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .ctrl_src(ctrl_src), .reads(reads),
    .receive_done(rxd), .receive_overrun_flag(ovr), .receive_event_mask(rxm),
    .transmit_done(txd), .transmit_underrun_flag(und), .transmit_event_mask(txm),
    .refusal_event_register(nak), .refusal_event_mask(nakm), .alternate_event_register(alt),
    .alternate_event_mask(altm), .fifo_warning_register(warn), .fifo_warning_mask(warnm),
    .charger_status(chg), .irq(irq));
  uma_evt_model ev (.aclk(aclk), .ctrl_src(ctrl_src), .reads(reads), .rxd(rxd), .ovr(ovr),
    .rxm(rxm), .txd(txd), .und(und), .txm(txm), .nak(nak), .nakm(nakm), .alt(alt), .altm(altm),
    .warn(warn), .warnm(warnm), .chg(chg));

  initial forever #5 aclk = ~aclk;

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  always @(posedge aclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      fail_count++;
      end_of_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // handshakes are judged at the negedge, acted on at the next rising edge
  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    logic b, aw, w;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    do
    begin
      @(negedge aclk);
      {b, r, aw, w} = {bvalid, bresp, awready, wready};
      @(posedge aclk);
      if (aw)
        awvalid <= 1'h0;
      if (w)
        wvalid <= 1'h0;
    end while (!b);
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    logic v, ar;
    araddr <= a;
    arvalid <= 1'h1;
    do
    begin
      @(negedge aclk);
      {v, d, r, ar} = {rvalid, rdata, rresp, arready};
      @(posedge aclk);
      if (ar)
        arvalid <= 1'h0;
    end while (!v);
  endtask

  function automatic logic [31:0] mval(input int p, input int b);
    logic [15:0] m;
    m = (p == 0) ? 16'h0FFF : (p == 1) ? (16'h0FFF & ~(16'h0001 << b)) : 16'h0F7F;
    return {16'h0000, m};
  endfunction

  initial
  begin
    logic [31:0] d, got;
    logic [1:0] r;
    got = $urandom(32'h080B);
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    rd(SUM_A, got, r);
    chk(got, {16'h0000, uma_pkg::SUMMARY_RESET}, "summary reset");
    rd(MASK_A, got, r);
    chk(got, {16'h0000, uma_pkg::MASK_RESET}, "mask reset");
    rd(12'h100, got, r);
    chk({got[29:0], r}, {30'h0, uma_pkg::RESP_DECERR}, "unmapped read");
    wr(12'h100, 32'hFFFFFFFF, r);
    chk({30'h0, r}, {30'h0, uma_pkg::RESP_DECERR}, "unmapped write");
    $display("register access test done");
    for (int i = 0; i < 17; i++)
    begin
      d = (i == 0) ? 32'hFFFFFFFF : $urandom;
      wr(MASK_A, d, r);
      rd(MASK_A, got, r);
      chk(got, d & {16'h0000, uma_pkg::MASK_WRITABLE}, "mask readback");
    end
    wstrb <= 4'h1;
    wr(MASK_A, 32'h00000000, r);
    wstrb <= 4'hF;
    rd(MASK_A, got, r);
    chk(got, d & 32'h00000F00, "mask low lane only");
    $display("mask test done");
    foreach (bits[i])
      for (int p = 0; p < 3; p++)
      begin
        wr(MASK_A, mval(p, bits[i]), r);
        ev.fire(bits[i]);
        @(negedge aclk);
        chk({31'h0, irq}, {31'h0, p == 0}, "irq on event");
        @(posedge aclk);
        rd(SUM_A, got, r);
        chk(got, 32'h1 << bits[i], "summary set");
        ev.clear(bits[i]);
        rd(SUM_A, got, r);
        chk(got, 32'h0, "summary cleared");
        @(negedge aclk);
        chk({31'h0, irq}, 32'h0, "irq after clear");
        @(posedge aclk);
      end
    $display("event test done");
    ev.fault(4'h1);
    rd(SUM_A, got, r);
    chk(got, 32'h0, "endpoint 0 fault");
    ev.fault(4'h2);
    rd(SUM_A, got, r);
    chk(got, 32'h44, "endpoint 1 fault");
    ev.fault(4'h0);
    rd(SUM_A, got, r);
    chk(got, 32'h0, "fault cleared");
    $display("fault test done");
    wr(SUM_A, 32'hFFFFFFFF, r);
    chk({30'h0, r}, {30'h0, uma_pkg::RESP_OKAY}, "summary write response");
    rd(SUM_A, got, r);
    chk(got, 32'h0, "summary not writable");
    rd(LATCH_A, got, r);
    chk(got, 32'h00000F7F, "rise capture");
    rd(LATCH_A, got, r);
    chk(got, 32'h0, "rise capture cleared");
    $display("capture test done");
    end_of_test();
  end
endmodule // uma_event_aggregator_tb
